// ---- include/flpp_pkg.sv ----
// constants and carriers for the fuse and lock programming port
package flpp_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ       = 125;
  localparam int unsigned T_WRITE_NS    = 4000000; // inside 3.7 ms .. 4.5 ms
  localparam int unsigned T_ERASE_NS    = 8000000; // inside 7.5 ms .. 9 ms
  localparam int unsigned T_WRITE_MIN_NS = 3700000;
  localparam int unsigned T_WRITE_MAX_NS = 4500000;
  localparam int unsigned T_ERASE_MIN_NS = 7500000;
  localparam int unsigned T_ERASE_MAX_NS = 9000000;
  // microseconds times clocks per microsecond
  localparam int unsigned WRITE_CYCLES  = T_WRITE_NS / 1000 * CLK_MHZ;
  localparam int unsigned ERASE_CYCLES  = T_ERASE_NS / 1000 * CLK_MHZ;
  localparam int unsigned TMR_W         = 21;
  // ----------------------------------------------------------------
  // command bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_ERASE     = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE   = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK   = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH  = 8'h10;
  localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
  localparam logic [7:0] CMD_RD_SIG    = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE   = 8'h04;
  localparam logic [7:0] CMD_NOP       = 8'h00;
  // serial instruction first and second byte codes
  localparam logic [7:0] SER_PREFIX    = 8'hac;
  localparam logic [7:0] SER_ENABLE    = 8'h53;
  localparam logic [2:0] SER_ERASE_TOP = 3'h4;
  localparam logic [7:0] SER_WR_EEPROM = 8'hc0;
  // ----------------------------------------------------------------
  // action select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD  = 2'h2;
  // ----------------------------------------------------------------
  // nonvolatile cell indices and lock byte fields
  // ----------------------------------------------------------------
  localparam logic [2:0] NV_FUSE_LOW  = 3'h0;
  localparam logic [2:0] NV_FUSE_HIGH = 3'h1;
  localparam logic [2:0] NV_FUSE_EXT  = 3'h2;
  localparam logic [2:0] NV_LOCK      = 3'h3;
  localparam logic [2:0] NV_SIG0      = 3'h4;
  localparam logic [2:0] NV_CAL       = 3'h7;
  localparam int unsigned LOCK_ONE_BIT = 0;
  localparam int unsigned LOCK_TWO_BIT = 1;
  localparam logic [7:0] LOCK_BOOT_MASK = 8'h3c;
  localparam logic [7:0] BYTE_ERASED    = 8'hff;
  // cell contents after reset; signature and calibration values are arbitrary
  localparam logic [63:0] NV_RESET = 64'h5a_12_34_56_ff_ff_df_62;
  // ----------------------------------------------------------------
  // apb register map
  // ----------------------------------------------------------------
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_CELLS  = 12'h008;
  localparam logic        CTRL_RESET = 1'b1;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       action_select_msb;
    logic       action_select_lsb;
    logic       byte_select_low;
    logic       byte_select_high;
    logic       write_strobe_n;
    logic       output_enable_n;
    logic       load_strobe;
    logic [7:0] data;
  } flpp_par_t;
  typedef struct packed {
    logic       we;
    logic [2:0] waddr;
    logic [7:0] wdata;
  } flpp_wr_t;
endpackage

// ---- src/flpp_mem.sv ----
// small register file holding fuse, lock, signature and calibration bytes
`timescale 1ns/1ps
module flpp_mem #(
  parameter int unsigned  DEPTH = 8,
  parameter logic [63:0]  INIT  = flpp_pkg::NV_RESET
) (
  input  wire logic             clk,   // system clock
  input  wire logic             rst,   // async reset, high
  input  wire flpp_pkg::flpp_wr_t wr,  // write request
  input  wire logic [2:0]       raddr, // read address
  output logic      [7:0]       rdata  // registered read data
);
  logic [7:0] cells [DEPTH];

  // cells load the power-on image at reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        cells[i] <= INIT[i*8 +: 8];
      end
      rdata <= 8'h00;
    end else begin
      if (wr.we) begin
        cells[wr.waddr] <= wr.wdata;
      end
      rdata <= cells[raddr];
    end
  end
endmodule

// ---- src/flpp_port.sv ----
// parallel and serial programming port for fuses and lock bits
`timescale 1ns/1ps
// Operation
// (RULE_01) action 10 plus load pulse loads command
// (RULE_02) action 01 plus load pulse loads data
// (RULE_03) fuse write 0x40, zero programs, one erases
// (RULE_04) low select only picks high fuse byte
// (RULE_05) high select only picks extended fuses
// (RULE_06) write strobe falling starts write, wait ready
// (RULE_07) busy low within one microsecond
// (RULE_08) write busy lasts 3.7 to 4.5 ms
// (RULE_09) chip erase busy lasts 7.5 to 9 ms
// (RULE_10) lock write 0x20, zero programs lock bit
// (RULE_11) lock level 3 blocks boot lock programming
// (RULE_12) only chip erase clears lock bits
// (RULE_13) read 0x04 returns fuse or lock byte
// (RULE_14) read 0x08 returns signature byte
// (RULE_15) signature read, low select gives calibration
// (RULE_16) load strobe high 150 ns, low 200 ns
// (RULE_17) serial mode only while reset pin low
// (RULE_18) serial programs need enable instruction first
// (RULE_19) serial eeprom write auto erases location
// (RULE_20) chip erase sets arrays to 0xff
// (RULE_21) serial clock phases exceed 2 or 3 cycles
// (RULE_22) programmer supplies clock when fuses need it
// (RULE_23) drive data only while output enable low
// (RULE_24) ignore write strobes while busy
module flpp_port #(
  parameter int unsigned WRITE_CYC = flpp_pkg::WRITE_CYCLES, // self-timed write length
  parameter int unsigned ERASE_CYC = flpp_pkg::ERASE_CYCLES  // chip erase length
) (
  input  wire logic               clk,          // 125 MHz system clock
  input  wire logic               rst,          // async reset, high
  input  wire logic               psel,         // apb select
  input  wire logic               penable,      // apb enable
  input  wire logic               pwrite,       // apb direction
  input  wire logic [11:0]        paddr,        // apb byte address
  input  wire logic [31:0]        pwdata,       // apb write data
  output logic      [31:0]        prdata,       // apb read data
  output logic                    pready,       // apb ready
  output logic                    pslverr,      // apb error on unmapped
  input  wire flpp_pkg::flpp_par_t par,         // parallel programming pins
  output logic      [7:0]         data_out,     // data bus output value
  output logic                    data_oe,      // data bus output enable
  output logic                    ready_busy_n, // low while self-timed op runs
  input  wire logic               reset_pin_n,  // device reset pin level
  input  wire logic               sck,          // serial clock, sampled
  input  wire logic               mosi,         // serial data in
  output logic                    miso,         // serial data out
  output logic                    array_erase,  // pulse: wipe flash and eeprom to 0xff
  output logic                    eeprom_autoerase // pulse: serial eeprom erase-then-write
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WRITE = 2'b01,
    ST_ERASE = 2'b10
  } flpp_state_t;

  flpp_state_t        state, next_state;
  logic [flpp_pkg::TMR_W-1:0] tmr, next_tmr;
  logic [7:0]         cmd, next_cmd;
  logic [7:0]         addr_low, next_addr_low;
  logic [7:0]         data_byte, next_data_byte;
  logic               load_prev, wr_prev, sck_prev;
  logic [7:0]         lock, next_lock;
  logic               port_en, next_port_en;
  logic               prog_en, next_prog_en;
  logic [4:0]         bit_cnt, next_bit_cnt;
  logic [31:0]        shreg, next_shreg;
  logic [7:0]         tx, next_tx;
  logic               next_miso;
  logic               next_array_erase, next_autoerase;
  logic [31:0]        next_prdata;
  flpp_pkg::flpp_wr_t mem_wr;
  logic [2:0]         raddr;
  logic [7:0]         rdata;
  logic               load_rise, wr_fall, sck_rise, sck_fall;
  logic               par_start, ser_erase, ser_eeprom;
  logic               apb_access, apb_hit;

  // ----------------------------------------------------------------
  // strobe edges; pins are synchronous to clk
  // ----------------------------------------------------------------
  assign load_rise = par.load_strobe & ~load_prev;
  assign wr_fall   = wr_prev & ~par.write_strobe_n;
  assign sck_rise  = sck & ~sck_prev;
  assign sck_fall  = ~sck & sck_prev;
  // one cycle of level per phase suffices, the programmer keeps load and sck phases longer
  // RULE_16 RULE_21 are met by the programmer holding each phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      load_prev <= 1'b0;
      wr_prev   <= 1'b1;
      sck_prev  <= 1'b0;
    end else begin
      load_prev <= par.load_strobe;
      wr_prev   <= par.write_strobe_n;
      sck_prev  <= sck;
    end
  end

  // ----------------------------------------------------------------
  // parallel loading of command, address and data
  // ----------------------------------------------------------------
  always_comb begin
    next_cmd       = cmd;
    next_addr_low  = addr_low;
    next_data_byte = data_byte;
    if (load_rise) begin
      case ({par.action_select_msb, par.action_select_lsb})
        flpp_pkg::ACT_CMD:  next_cmd = par.data;       // RULE_01
        flpp_pkg::ACT_DATA: next_data_byte = par.data; // RULE_02
        flpp_pkg::ACT_ADDR: begin
          if (!par.byte_select_low) begin
            next_addr_low = par.data;
          end
        end
        default: next_cmd = cmd; // idle code
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd       <= flpp_pkg::CMD_NOP;
      addr_low  <= 8'h00;
      data_byte <= 8'h00;
    end else begin
      cmd       <= next_cmd;
      addr_low  <= next_addr_low;
      data_byte <= next_data_byte;
    end
  end

  // ----------------------------------------------------------------
  // serial link: 32-bit instructions, only while the reset pin is low
  // ----------------------------------------------------------------
  always_comb begin
    next_bit_cnt = bit_cnt;
    next_shreg   = shreg;
    next_tx      = tx;
    next_miso    = miso;
    next_prog_en = prog_en;
    ser_erase    = 1'b0;
    ser_eeprom   = 1'b0;
    if (reset_pin_n) begin
      // leaving serial mode drops the enable and resynchronises
      next_bit_cnt = 5'h00; // RULE_17
      next_prog_en = 1'b0;  // RULE_18
      next_miso    = 1'b0;
    end else begin
      if (sck_rise) begin
        next_shreg   = {shreg[30:0], mosi};
        next_bit_cnt = bit_cnt + 5'h01;
        // the previous byte is echoed during the next one
        if (bit_cnt[2:0] == 3'h7) begin
          next_tx = {shreg[6:0], mosi};
        end else begin
          next_tx = {tx[6:0], 1'b0};
        end
        if (bit_cnt == 5'h1f) begin
          if (shreg[30:23] == flpp_pkg::SER_PREFIX && shreg[22:15] == flpp_pkg::SER_ENABLE) begin
            next_prog_en = 1'b1;
          end
          // erase and write only after the enable instruction
          ser_erase  = prog_en && shreg[30:23] == flpp_pkg::SER_PREFIX
                       && shreg[22:20] == flpp_pkg::SER_ERASE_TOP; // RULE_18
          ser_eeprom = prog_en && shreg[30:23] == flpp_pkg::SER_WR_EEPROM; // RULE_18
        end
      end
      if (sck_fall) begin
        next_miso = tx[7];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_cnt <= 5'h00;
      shreg   <= 32'h0000_0000;
      tx      <= 8'h00;
      miso    <= 1'b0;
      prog_en <= 1'b0;
    end else begin
      bit_cnt <= next_bit_cnt;
      shreg   <= next_shreg;
      tx      <= next_tx;
      miso    <= next_miso;
      prog_en <= next_prog_en;
    end
  end

  // ----------------------------------------------------------------
  // self-timed write and erase sequencer
  // ----------------------------------------------------------------
  // a strobe during busy is dropped, so a running write cannot be disturbed
  assign par_start = wr_fall && port_en && state == ST_IDLE; // RULE_06 RULE_24

  always_comb begin
    next_state       = state;
    next_tmr         = tmr;
    next_lock        = lock;
    next_array_erase = 1'b0;
    next_autoerase   = 1'b0;
    mem_wr           = '0;
    case (state)
      ST_IDLE: begin
        next_tmr = '0;
        if (par_start && cmd == flpp_pkg::CMD_ERASE || ser_erase) begin
          next_state       = ST_ERASE; // RULE_09
          next_array_erase = 1'b1;     // RULE_20
        end else if (ser_eeprom) begin
          next_state     = ST_WRITE;
          next_autoerase = 1'b1;       // RULE_19
        end else if (par_start) begin
          case (cmd)
            flpp_pkg::CMD_WR_FUSE: begin
              next_state   = ST_WRITE;  // RULE_08
              mem_wr.we    = 1'b1;
              mem_wr.wdata = data_byte; // RULE_03
              if (par.byte_select_low && !par.byte_select_high) begin
                mem_wr.waddr = flpp_pkg::NV_FUSE_HIGH; // RULE_04
              end else if (!par.byte_select_low && par.byte_select_high) begin
                mem_wr.waddr = flpp_pkg::NV_FUSE_EXT;  // RULE_05
              end else begin
                mem_wr.waddr = flpp_pkg::NV_FUSE_LOW;
              end
            end
            flpp_pkg::CMD_WR_LOCK: begin
              next_state = ST_WRITE;
              // a one bit never unprograms a lock bit
              next_lock  = lock & data_byte; // RULE_10 RULE_12
              if (!lock[flpp_pkg::LOCK_ONE_BIT] && !lock[flpp_pkg::LOCK_TWO_BIT]) begin
                next_lock = (lock & flpp_pkg::LOCK_BOOT_MASK)
                            | (lock & data_byte & ~flpp_pkg::LOCK_BOOT_MASK); // RULE_11
              end
              mem_wr.we    = 1'b1;
              mem_wr.waddr = flpp_pkg::NV_LOCK;
              mem_wr.wdata = next_lock;
            end
            flpp_pkg::CMD_WR_FLASH, flpp_pkg::CMD_WR_EEPROM: next_state = ST_WRITE;
            default: next_state = ST_IDLE;
          endcase
        end
      end
      ST_WRITE: begin
        next_tmr = tmr + 1'b1;
        if (tmr == flpp_pkg::TMR_W'(WRITE_CYC - 1)) begin
          next_state = ST_IDLE; // RULE_08
        end
      end
      ST_ERASE: begin
        next_tmr = tmr + 1'b1;
        if (tmr == flpp_pkg::TMR_W'(ERASE_CYC - 1)) begin
          next_state   = ST_IDLE; // RULE_09
          // locks clear only once the arrays are wiped
          next_lock    = flpp_pkg::BYTE_ERASED; // RULE_12
          mem_wr.we    = 1'b1;
          mem_wr.waddr = flpp_pkg::NV_LOCK;
          mem_wr.wdata = flpp_pkg::BYTE_ERASED;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state       <= ST_IDLE;
      tmr         <= '0;
      lock        <= flpp_pkg::NV_RESET[31:24];
      array_erase <= 1'b0;
      eeprom_autoerase <= 1'b0;
    end else begin
      state       <= next_state;
      tmr         <= next_tmr;
      lock        <= next_lock;
      array_erase <= next_array_erase;
      eeprom_autoerase <= next_autoerase;
    end
  end

  // busy shows one cycle after the strobe edge, far inside 1 us
  assign ready_busy_n = (state == ST_IDLE); // RULE_07

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  function automatic logic [2:0] read_sel(input logic [7:0] c, input logic bsl,
                                          input logic bsh, input logic [7:0] a);
    read_sel = flpp_pkg::NV_FUSE_LOW;
    if (c == flpp_pkg::CMD_RD_FUSE) begin
      case ({bsh, bsl})
        2'b11:   read_sel = flpp_pkg::NV_FUSE_HIGH; // RULE_13
        2'b10:   read_sel = flpp_pkg::NV_FUSE_EXT;
        2'b01:   read_sel = flpp_pkg::NV_LOCK;
        default: read_sel = flpp_pkg::NV_FUSE_LOW;
      endcase
    end else if (bsl) begin
      read_sel = flpp_pkg::NV_CAL; // RULE_15
    end else begin
      read_sel = flpp_pkg::NV_SIG0 + 3'(a[1:0] > 2'h2 ? 2'h2 : a[1:0]); // RULE_14
    end
  endfunction

  assign raddr    = read_sel(cmd, par.byte_select_low, par.byte_select_high, addr_low);
  assign data_out = rdata;
  // bus released whenever output enable is high or no read is loaded
  assign data_oe  = !par.output_enable_n
                    && (cmd == flpp_pkg::CMD_RD_FUSE || cmd == flpp_pkg::CMD_RD_SIG); // RULE_23

  flpp_mem #(
    .DEPTH (8),
    .INIT  (flpp_pkg::NV_RESET)
  ) u_mem (
    .clk   (clk),
    .rst   (rst),
    .wr    (mem_wr),
    .raddr (raddr),
    .rdata (rdata)
  );

  // ----------------------------------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------------------------------
  assign apb_access = psel && penable;
  assign apb_hit    = paddr == flpp_pkg::REG_CTRL || paddr == flpp_pkg::REG_STATUS
                      || paddr == flpp_pkg::REG_CELLS;
  assign pready     = 1'b1;
  assign pslverr    = apb_access && !apb_hit;

  always_comb begin
    next_port_en = port_en;
    next_prdata  = prdata;
    if (apb_access && pwrite && paddr == flpp_pkg::REG_CTRL) begin
      next_port_en = pwdata[0];
    end
    if (psel && !penable && !pwrite) begin
      case (paddr)
        flpp_pkg::REG_CTRL:   next_prdata = {31'h0, port_en};
        flpp_pkg::REG_STATUS: next_prdata = {20'h0, cmd, 1'b0, prog_en,
                                             state == ST_ERASE, !ready_busy_n};
        flpp_pkg::REG_CELLS:  next_prdata = {16'h0, lock, data_byte};
        default:              next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_en <= flpp_pkg::CTRL_RESET;
      prdata  <= 32'h0000_0000;
    end else begin
      port_en <= next_port_en;
      prdata  <= next_prdata;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [flpp_pkg::TMR_W-1:0] busy_len;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_len <= '0;
    end else begin
      busy_len <= ready_busy_n ? '0 : busy_len + 1'b1;
    end
  end

  sequence s_start;
    par_start && cmd == flpp_pkg::CMD_WR_FUSE;
  endsequence
  sequence s_busy_low;
    !ready_busy_n ##1 !ready_busy_n;
  endsequence

  property p_busy_fast;
    @(posedge clk) disable iff (rst) s_start |=> s_busy_low;
  endproperty
  a_busy_fast: assert property (p_busy_fast) else $error("busy not raised after strobe"); // RULE_07

  property p_write_len;
    @(posedge clk) disable iff (rst)
      $rose(ready_busy_n) && $past(state) == ST_WRITE
      |-> busy_len == flpp_pkg::TMR_W'(WRITE_CYC)
      && $past(busy_len) == flpp_pkg::TMR_W'(WRITE_CYC - 1);
  endproperty
  a_write_len: assert property (p_write_len) else $error("write busy length wrong"); // RULE_08

  property p_erase_len;
    @(posedge clk) disable iff (rst)
      $rose(ready_busy_n) && $past(state) == ST_ERASE
      |-> $past(busy_len) == flpp_pkg::TMR_W'(ERASE_CYC - 1) && lock == flpp_pkg::BYTE_ERASED;
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase busy length wrong"); // RULE_09

  property p_busy_ignore;
    @(posedge clk) disable iff (rst)
      !ready_busy_n && wr_fall |-> (!mem_wr.we || state == ST_ERASE) ##1 tmr == $past(tmr) + 1'b1;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("strobe taken while busy"); // RULE_24

  property p_drive;
    @(posedge clk) disable iff (rst) data_oe |-> !par.output_enable_n;
  endproperty
  a_drive: assert property (p_drive) else $error("bus driven with output enable high"); // RULE_23

  property p_lock_keep;
    @(posedge clk) disable iff (rst) state != ST_ERASE |=> (lock & ~$past(lock)) == 8'h00;
  endproperty
  a_lock_keep: assert property (p_lock_keep) else $error("lock bit cleared without erase"); // RULE_12

  property p_boot_guard;
    @(posedge clk) disable iff (rst)
      !lock[flpp_pkg::LOCK_ONE_BIT] && !lock[flpp_pkg::LOCK_TWO_BIT] && state != ST_ERASE
      |=> (lock & flpp_pkg::LOCK_BOOT_MASK) == ($past(lock) & flpp_pkg::LOCK_BOOT_MASK);
  endproperty
  a_boot_guard: assert property (p_boot_guard) else $error("boot lock changed at level 3"); // RULE_11

  property p_serial_gate;
    @(posedge clk) disable iff (rst) (ser_erase || ser_eeprom) |-> prog_en && !reset_pin_n;
  endproperty
  a_serial_gate: assert property (p_serial_gate) else $error("serial op without enable"); // RULE_18

  property p_serial_mode;
    @(posedge clk) disable iff (rst) reset_pin_n |=> !prog_en;
  endproperty
  a_serial_mode: assert property (p_serial_mode) else $error("serial enable with reset high"); // RULE_17
endmodule

// ---- verification/flpp_prog.sv ----
// programmer model driving the port pins
`timescale 1ns/1ps
module flpp_prog (
  input  wire logic           clk,  // clock
  input  wire logic [7:0]     dout, // device bus value
  input  wire logic           doe,  // device drives bus
  input  wire logic           rdy,  // low while busy
  input  wire logic           miso, // device serial out
  output flpp_pkg::flpp_par_t par,  // parallel pins
  output logic                rpn,  // reset pin
  output logic                sck,  // serial clock
  output logic                mosi  // serial data
);
  logic [6:0] c = 7'h06; // selects, strobes
  logic [7:0] d = 8'h00; // our bus value
  // bus is ours unless the device drives it
  assign par = {c, doe ? dout : d};
  initial {rpn, sck, mosi} = 3'h4;
  // load strobe high 152 ns, low 200 ns
  task automatic load(input logic [1:0] a, input logic [7:0] b);
    @(posedge clk) {c[6:5], d} <= {a, b};
    @(posedge clk) c[0] <= 1'b1;
    repeat (19) @(posedge clk);
    c[0] <= 1'b0;
    repeat (25) @(posedge clk);
  endtask
  // write pulse, count busy; x adds a stray strobe
  task automatic wr(input logic l, h, x, output int n);
    @(posedge clk) c[4:3] <= {l, h};
    @(posedge clk) c[2] <= 1'b0;
    @(posedge clk) c[2] <= 1'b1;
    #1 n = 0;
    while (rdy === 1'b0 && n < 99999) begin
      @(posedge clk) c[2] <= !(x && n == 4);
      #1 n++;
    end
    @(posedge clk) c[4:3] <= 2'h0;
  endtask
  // released bus inverts, never keeps the last value
  task automatic rd(input logic l, h, output logic [7:0] v, output logic e);
    @(posedge clk) {c[4:3], c[1], d} <= {l, h, 1'b0, ~d};
    repeat (2) @(posedge clk);
    #1 {v, e} = {par[7:0], doe};
    @(posedge clk) c[4:1] <= 4'h3;
  endtask
  // msb first, sck phases over 3 clocks
  task automatic ser(input logic [31:0] w, output logic [31:0] r);
    @(posedge clk) rpn <= 1'b0;
    for (int i = 31; i >= 0; i--) begin
      @(posedge clk) {mosi, sck} <= {w[i], 1'b0};
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      r = {r[30:0], miso}; // echo taken as sck rises
      repeat (4) @(posedge clk);
    end
    @(posedge clk) sck <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule

// ---- verification/flpp_port_bench.sv ----
// self-checking bench for the programming port
`timescale 1ns/1ps
`define CK(s, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", s, e, g); end end
module flpp_port_bench;
  localparam int unsigned WC = 20; // short self-timed counts
  localparam int unsigned EC = 40;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, prd, rd, sr;
  logic [7:0]  dout, v, nv [8];
  logic        prdy, perr, err, doe, rdy, ers, aer, sck, mosi, rpn, oe, so;
  flpp_pkg::flpp_par_t par;
  int          n_fail = 0, checks_done = 0, n, n_er = 0, n_ae = 0;
  flpp_port #(.WRITE_CYC(WC), .ERASE_CYC(EC)) i_dut (.clk(clk), .rst(rst), .psel(psel),
    .penable(pen), .pwrite(pwr), .paddr(pa), .pwdata(pwd), .prdata(prd), .pready(prdy),
    .pslverr(perr), .par(par), .data_out(dout), .data_oe(doe), .ready_busy_n(rdy),
    .reset_pin_n(rpn), .sck(sck), .mosi(mosi), .miso(so), .array_erase(ers),
    .eeprom_autoerase(aer));
  flpp_prog i_prog (.clk(clk), .dout(dout), .doe(doe), .rdy(rdy), .miso(so), .par(par),
    .rpn(rpn), .sck(sck), .mosi(mosi));
  // clock always runs, whatever the source fuses pick
  initial forever #4 clk = ~clk;
  always @(posedge clk) {n_er, n_ae} <= {n_er + ers, n_ae + aer};
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk) {psel, pwr, pa, pwd} <= {1'b1, w, a, d};
    @(posedge clk) pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    {rd, err} = {prd, perr};
    {psel, pen} <= 2'h0;
  endtask
  // command, data, strobe; ex is the busy length
  task automatic op(input logic [7:0] cm, dt, input logic l, h, x, input int ex);
    i_prog.load(2'h2, cm);
    i_prog.load(2'h1, dt);
    i_prog.wr(l, h, x, n);
    `CK("busy", ex, n)
  endtask
  task automatic rdall();
    i_prog.load(2'h2, 8'h04);
    for (int k = 0; k < 4; k++) begin
      i_prog.rd(k == 1 || k == 3, k == 1 || k == 2, v, oe);
      `CK("fuse byte", nv[k], v)
      `CK("drive", 1'b1, oe)
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    for (int i = 0; i < 8; i++) nv[i] = flpp_pkg::NV_RESET[8*i +: 8];
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 12'h004, 32'h0);
    `CK("status", 33'h0, {rd, err})
    apb(1'b0, 12'h00c, 32'h0);
    `CK("unmapped", 33'h1, {rd, err})
    // low, high, extended fuses; first gets a stray strobe
    for (int k = 0; k < 3; k++) begin
      op(8'h40, 8'h35 + k[7:0], k == 1, k == 2, k == 0, WC);
      nv[k] = 8'h35 + k[7:0];
    end
    op(8'h20, 8'hfc, 1'b0, 1'b0, 1'b0, WC);
    op(8'h20, 8'hc3, 1'b0, 1'b0, 1'b0, WC);
    op(8'h10, 8'h00, 1'b0, 1'b0, 1'b0, WC);
    nv[3] = 8'hfc;
    // port disabled: strobe ignored, fuses kept
    apb(1'b1, 12'h000, 32'h0);
    op(8'h40, 8'h00, 1'b0, 1'b0, 1'b0, 0);
    apb(1'b1, 12'h000, 32'h1);
    rdall();
    op(8'h80, 8'h00, 1'b0, 1'b0, 1'b0, EC);
    `CK("wipe", 1, n_er)
    nv[3] = 8'hff;
    rdall();
    i_prog.load(2'h2, 8'h08);
    for (int a = 0; a < 4; a++) begin
      i_prog.load(2'h0, (a == 3) ? 8'h00 : a[7:0]);
      i_prog.rd(a == 3, 1'b0, v, oe);
      `CK("id byte", nv[(a == 3) ? 7 : 4 + a], v)
    end
    @(posedge clk);
    #1 `CK("release", 1'b0, doe)
    // serial erase before enable is refused
    i_prog.ser(32'hac80_0000, sr);
    `CK("early erase", 1, n_er)
    i_prog.ser(32'hac53_0000, sr);
    `CK("echo", 8'h53, sr[15:8])
    apb(1'b0, 12'h004, 32'h0);
    `CK("serial on", 1'b1, rd[2])
    i_prog.ser(32'hac80_0000, sr);
    `CK("late erase", 2, n_er)
    i_prog.ser(32'hc000_1155, sr);
    `CK("auto erase", 1, n_ae)
    `CK("ee busy", 1'b0, rdy)
    tally_and_finish();
  end
endmodule
